/* File: design/octal_dac_serial_command_port.v */
// serial command port and register file of an eight channel 8-bit dac
// assumes shift_clock, chip_select_n, serial_in, load_dac_n are pins, sampled by clk_sys
`include "octal_dac_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module octal_dac_serial_command_port (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire        shift_clock,
	input  wire        chip_select_n,
	input  wire        serial_in,
	input  wire        load_dac_n,
	output reg         serial_out,
	output wire        serial_out_oe,
	output reg  [7:0]  out_a_a,
	output reg  [7:0]  out_b_b,
	output reg  [7:0]  out_c_c,
	output reg  [7:0]  out_d_d,
	output reg  [7:0]  out_e_e,
	output reg  [7:0]  out_f_f,
	output reg  [7:0]  out_g_g,
	output reg  [7:0]  out_h_h,
	output reg  [7:0]  buffer_enable,
	output reg         phase_mode,
	output reg         word_complete
);
	wire        sclk_s;
	wire        cs_n_s;
	wire        din_s;
	wire        load_dac_n_n_s;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        cs_rise;
	wire        cs_fall;
	reg  [15:0] shift_reg;
	reg  [15:0] shift_next;
	reg  [4:0]  count_reg;
	reg  [7:0]  input_reg [0:7];
	reg  [7:0]  dac_reg   [0:7];
	reg  [7:0]  mask_reg;
	reg         phase_reg;
	reg         out_bit_reg;
	integer     i;

	wire [2:0]  addr_field = shift_reg[`ADDR_MSB_POS:`ADDR_LSB_POS];
	wire [2:0]  ctrl_field = shift_reg[`CTRL_MSB_POS:`CTRL_LSB_POS];
	wire [7:0]  code_field = shift_reg[`CODE_MSB_POS:0];
	wire        addr_field_msb = addr_field[2];

	pin_sync u_sync_sclk (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.reset_level  (1'b0),
		.pin_in       (shift_clock),
		.pin_sync_out (sclk_s)
	);
	pin_sync u_sync_cs (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.reset_level  (1'b1),
		.pin_in       (chip_select_n),
		.pin_sync_out (cs_n_s)
	);
	pin_sync u_sync_din (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.reset_level  (1'b0),
		.pin_in       (serial_in),
		.pin_sync_out (din_s)
	);
	pin_sync u_sync_load_dac_n (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.reset_level  (1'b1),
		.pin_in       (load_dac_n),
		.pin_sync_out (load_dac_n_n_s)
	);
	edge_find u_edge_sclk (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.level_in   (sclk_s),
		.rise_pulse (sclk_rise),
		.fall_pulse (sclk_fall)
	);
	edge_find u_edge_cs (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.level_in   (cs_n_s),
		.rise_pulse (cs_rise),
		.fall_pulse (cs_fall)
	);

	assign serial_out_oe = 1'b1;

	// shift register and bit counter
	always @* begin
		shift_next = {shift_reg[14:0], din_s};
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			shift_reg   <= `WORD_ZERO;
			count_reg   <= `CNT_ZERO;
			out_bit_reg <= 1'b0;
			serial_out  <= 1'b0;
		end else begin
			if (cs_fall) begin
				count_reg <= `CNT_ZERO;
			end else if (!cs_n_s && sclk_rise) begin
				shift_reg <= shift_next;
				if (count_reg != `CNT_FULL) begin
					count_reg <= count_reg + 5'h01;
				end
				out_bit_reg <= shift_reg[15];
				if (phase_reg) begin
					serial_out <= shift_reg[15];
				end
			end
			if (!cs_n_s && sclk_fall && !phase_reg) begin
				serial_out <= out_bit_reg;
			end
		end
	end

	// command execution and register file
	always @(posedge clk_sys) begin
		if (!rstn) begin
			for (i = 0; i < `CHANNELS; i = i + 1) begin
				input_reg[i] <= `CODE_ZERO;
				dac_reg[i]   <= `CODE_ZERO;
			end
			mask_reg      <= `MASK_ON;
			phase_reg     <= 1'b0;
			word_complete <= 1'b0;
		end else begin
			word_complete <= 1'b0;
			if (cs_rise) begin
				word_complete <= (count_reg == `CNT_FULL);
				case (ctrl_field)
					`CTRL_NOP: begin
						mask_reg <= mask_reg;
					end
					`CTRL_CLEAR: begin
						for (i = 0; i < `CHANNELS; i = i + 1) begin
							input_reg[i] <= `CODE_ZERO;
							dac_reg[i]   <= `CODE_ZERO;
						end
						mask_reg <= `MASK_ON;
					end
					`CTRL_SHUTDOWN: begin
						mask_reg <= code_field;
					end
					`CTRL_PHASE: begin
						phase_reg <= addr_field_msb;
						for (i = 0; i < `CHANNELS; i = i + 1) begin
							dac_reg[i] <= input_reg[i];
						end
					end
					`CTRL_LOAD_SAME: begin
						for (i = 0; i < `CHANNELS; i = i + 1) begin
							dac_reg[i] <= code_field;
						end
						mask_reg <= `MASK_ON;
					end
					`CTRL_LOAD_IN: begin
						input_reg[addr_field] <= code_field;
						if (!load_dac_n_n_s) begin
							dac_reg[addr_field] <= code_field;
						end
					end
					`CTRL_LOAD_BOTH: begin
						input_reg[addr_field] <= code_field;
						dac_reg[addr_field]   <= code_field;
						mask_reg              <= `MASK_ON;
					end
					`CTRL_LOAD_ALL: begin
						for (i = 0; i < `CHANNELS; i = i + 1) begin
							dac_reg[i] <= input_reg[i];
						end
					end
					default: begin
						mask_reg <= mask_reg;
					end
				endcase
			end else if (!load_dac_n_n_s) begin
				for (i = 0; i < `CHANNELS; i = i + 1) begin
					dac_reg[i] <= input_reg[i];
				end
			end
		end
	end

	// outputs registered from the dac, mask and phase registers
	always @(posedge clk_sys) begin
		if (!rstn) begin
			out_a_a       <= `CODE_ZERO;
			out_b_b       <= `CODE_ZERO;
			out_c_c       <= `CODE_ZERO;
			out_d_d       <= `CODE_ZERO;
			out_e_e       <= `CODE_ZERO;
			out_f_f       <= `CODE_ZERO;
			out_g_g       <= `CODE_ZERO;
			out_h_h       <= `CODE_ZERO;
			buffer_enable <= `MASK_ON;
			phase_mode    <= 1'b0;
		end else begin
			out_a_a       <= dac_reg[0];
			out_b_b       <= dac_reg[1];
			out_c_c       <= dac_reg[2];
			out_d_d       <= dac_reg[3];
			out_e_e       <= dac_reg[4];
			out_f_f       <= dac_reg[5];
			out_g_g       <= dac_reg[6];
			out_h_h       <= dac_reg[7];
			buffer_enable <= mask_reg;
			phase_mode    <= phase_reg;
		end
	end
endmodule // octal_dac_serial_command_port
`default_nettype wire

/* File: design/octal_dac_regs.vh */
// constants for the octal dac serial command port
// assumes inclusion by bare name from design files
`ifndef OCTAL_DAC_REGS_VH
`define OCTAL_DAC_REGS_VH
`define WORD_BITS       16
`define CODE_BITS       8
`define CHANNELS        8
`define ADDR_MSB_POS    13
`define ADDR_LSB_POS    11
`define CTRL_MSB_POS    10
`define CTRL_LSB_POS    8
`define CODE_MSB_POS    7
`define CTRL_NOP        3'h0
`define CTRL_CLEAR      3'h1
`define CTRL_SHUTDOWN   3'h2
`define CTRL_PHASE      3'h3
`define CTRL_LOAD_SAME  3'h4
`define CTRL_LOAD_IN    3'h5
`define CTRL_LOAD_BOTH  3'h6
`define CTRL_LOAD_ALL   3'h7
`define CODE_ZERO       8'h00
`define MASK_ON         8'hFF
`define WORD_ZERO       16'h0000
`define CNT_ZERO        5'h00
`define CNT_FULL        5'h10
`endif

/* File: design/pin_sync.v */
// two flip-flop synchroniser for one pin
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	input  wire clk_sys,
	input  wire rstn,
	input  wire reset_level,
	input  wire pin_in,
	output reg  pin_sync_out
);
	reg first_reg;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			first_reg    <= reset_level;
			pin_sync_out <= reset_level;
		end else begin
			first_reg    <= pin_in;
			pin_sync_out <= first_reg;
		end
	end
endmodule // pin_sync
`default_nettype wire

/* File: design/edge_find.v */
// rise and fall pulses of a synchronised level
// assumes the input is already in the clk_sys domain
`timescale 1ns/1ns
`default_nettype none
module edge_find (
	input  wire clk_sys,
	input  wire rstn,
	input  wire level_in,
	output wire rise_pulse,
	output wire fall_pulse
);
	reg last_reg;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			// follow the idle level so release makes no false edge
			last_reg <= level_in;
		end else begin
			last_reg <= level_in;
		end
	end
	assign rise_pulse = level_in & ~last_reg;
	assign fall_pulse = ~level_in & last_reg;
endmodule // edge_find
`default_nettype wire

/* File: verif/dac_port_chk_sva.sv */
// port checker for the octal dac serial command port
// assumes pins are sampled by clk_sys, frames spaced by the master model
`timescale 1ns/1ns
`default_nettype none
module dac_port_chk (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       shift_clock,
	input wire logic       chip_select_n,
	input wire logic       load_dac_n,
	input wire logic       serial_out,
	input wire logic       serial_out_oe,
	input wire logic [7:0] out_a_a,
	input wire logic [7:0] out_h_h,
	input wire logic [7:0] buffer_enable,
	input wire logic       phase_mode,
	input wire logic       word_complete
);
	logic [3:0] load_dac_n_age;
	// cycles since load input was last low
	always_ff @(posedge clk_sys)
		if (!rstn || !load_dac_n) load_dac_n_age <= 4'h0;
		else if (load_dac_n_age != 4'hf) load_dac_n_age <= load_dac_n_age + 4'h1;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	reset_state_a: assert property ($rose(rstn) |-> !out_a_a && buffer_enable == 8'hff && !phase_mode)
		else $error("bad reset state");
	oe_always_on_a: assert property (serial_out_oe)
		else $error("serial_out released");
	out_hold_idle_a: assert property (chip_select_n [*6] |-> $stable(serial_out))
		else $error("serial_out moved while idle");
	out_shift_only_a: assert property ($changed(serial_out) |-> !chip_select_n)
		else $error("serial_out moved outside frame");
	mode0_fall_a: assert property ($changed(serial_out) && !phase_mode |-> !$past(shift_clock) && !$past(shift_clock, 2))
		else $error("mode 0 edge wrong");
	mode1_rise_a: assert property ($changed(serial_out) && phase_mode |-> $past(shift_clock) && $past(shift_clock, 2))
		else $error("mode 1 edge wrong");
	dac_cause_a: assert property ($changed({out_a_a, out_h_h}) |-> chip_select_n || load_dac_n_age < 4'h8)
		else $error("dac output moved without cause");
	buf_cause_a: assert property ($changed(buffer_enable) |-> $past(chip_select_n, 3))
		else $error("buffer enable moved in frame");
	phase_cause_a: assert property ($changed(phase_mode) |-> chip_select_n && $past(chip_select_n, 3))
		else $error("phase moved in frame");
	done_pulse_a: assert property (word_complete |-> chip_select_n ##1 !word_complete)
		else $error("word_complete not a pulse");
endmodule // dac_port_chk
bind octal_dac_serial_command_port dac_port_chk chk (.clk_sys, .rstn, .shift_clock, .chip_select_n, .load_dac_n,
	.serial_out, .serial_out_oe, .out_a_a, .out_h_h, .buffer_enable, .phase_mode, .word_complete);
`default_nettype wire

/* File: verif/serial_master_model.sv */
// serial master model driving the command port pins
// assumes callers enter its tasks just after a clk_sys edge
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
	input  wire logic clk_sys,
	input  wire logic serial_out,
	output var  logic shift_clock,
	output var  logic chip_select_n,
	output var  logic serial_in
);
	initial begin
		shift_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		chip_select_n = 1'b0;
		serial_in = tx[15];
		tick(4);
		for (int i = 15; i >= 0; i--) begin
			shift_clock = 1'b1;
			tick(4);
			shift_clock = 1'b0;
			if (i > 0) serial_in = tx[i - 1];
			tick(4);
			// both phases show the earlier word's bit here
			rx[i] = serial_out;
		end
		tick(4);
		chip_select_n = 1'b1;
		serial_in = ~serial_in;
		tick(12);
	endtask
	// clock pulses while deselected
	task automatic stray();
		repeat (4) begin
			serial_in = 1'($urandom);
			shift_clock = 1'b1;
			tick(4);
			shift_clock = 1'b0;
			tick(4);
		end
	endtask
endmodule // serial_master_model
`default_nettype wire

/* File: verif/octal_dac_serial_command_port_tb.sv */
// self-checking bench for the octal dac serial command port
// assumes the serial master model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module octal_dac_serial_command_port_tb;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        load_dac_n = 1'b1;
	logic        shift_clock, chip_select_n, serial_in, serial_out, phase_mode, word_complete, phase_exp;
	logic [7:0]  outs [8];
	logic [7:0]  inr [8], dac [8], buffer_enable, mask_exp;
	logic [15:0] prev_word, rx, w;
	int          mismatches = 0, cmp_count = 0, done_cnt = 0;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (word_complete === 1'b1) done_cnt++;
	serial_master_model master (.clk_sys, .serial_out, .shift_clock, .chip_select_n, .serial_in);
	octal_dac_serial_command_port dut (.clk_sys, .rstn, .shift_clock, .chip_select_n, .serial_in, .load_dac_n,
		.serial_out, .serial_out_oe(), .out_a_a(outs[0]), .out_b_b(outs[1]), .out_c_c(outs[2]), .out_d_d(outs[3]),
		.out_e_e(outs[4]), .out_f_f(outs[5]), .out_g_g(outs[6]), .out_h_h(outs[7]), .buffer_enable, .phase_mode,
		.word_complete);
	task automatic chk(input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic void model(input logic [15:0] c);
		if (c[10:8] inside {3'h1, 3'h4, 3'h6}) mask_exp = 8'hff;
		if (c[10:8] == 3'h2) mask_exp = c[7:0];
		if (c[10:8] == 3'h3) phase_exp = c[13];
		for (int i = 0; i < 8; i++) begin
			if (c[10:8] == 3'h1) {inr[i], dac[i]} = 16'h0000;
			if (c[10:8] inside {3'h3, 3'h7}) dac[i] = inr[i];
			if (c[10:8] == 3'h4) dac[i] = c[7:0];
		end
		if (c[10:8] inside {3'h5, 3'h6}) inr[c[13:11]] = c[7:0];
		if (c[10:8] == 3'h6 || (c[10:8] == 3'h5 && !load_dac_n)) dac[c[13:11]] = c[7:0];
	endfunction
	task automatic check_outs;
		for (int i = 0; i < 8; i++) chk(outs[i], dac[i]);
		chk(buffer_enable, mask_exp);
		chk(phase_mode, phase_exp);
	endtask
	task automatic cmd(input logic [15:0] c);
		int d;
		d = done_cnt;
		master.xfer(c, rx);
		chk(rx, prev_word);
		chk(16'(done_cnt), 16'(d + 1));
		prev_word = c;
		model(c);
		check_outs();
	endtask
	initial begin
		w = $urandom(32'hd1c6_bf59);
		inr = '{default: 8'h00};
		dac = '{default: 8'h00};
		{mask_exp, phase_exp, prev_word} = {8'hff, 1'b0, 16'h0000};
		repeat (10) @(posedge clk_sys);
		#1 rstn = 1'b1;
		master.tick(4);
		cmd(16'hd8a5);
		master.stray();
		cmd(16'h0000);
		cmd(16'h2300);
		cmd(16'h3812);
		cmd(16'h0200);
		cmd(16'h04ff);
		for (int i = 0; i < 8; i++) cmd({2'b00, 3'(i), 3'h5, 8'(i * 37 + 1)});
		load_dac_n = 1'b0;
		master.tick(10);
		load_dac_n = 1'b1;
		master.tick(8);
		dac = inr;
		check_outs();
		load_dac_n = 1'b0;
		cmd(16'h155a);
		load_dac_n = 1'b1;
		for (int i = 0; i < 32; i++) begin
			w = $urandom;
			w[10:8] = 3'(i % 8);
			cmd(w);
		end
		give_verdict();
	end
	initial begin
		#5_000_000;
		mismatches++;
		give_verdict();
	end
endmodule // octal_dac_serial_command_port_tb
`default_nettype wire
